// ### rtl/pbs_pkg.sv
/*
  Shared constants and types of the pipelined burst SRAM port.
  Assumes a single rising-edge clock and a synchronous active-high reset.
*/
// Function
// - Controller strobe low at an edge captures the full 18-bit address.
// - Any accepted address strobe loads address bits 1:0 into the counter.
// - Both strobes low with select one low: only the processor strobe is acted on.
// - Sleep input high enters a quiet state; stored data is kept.
// - Write data and parity are taken in on the rising clock edge.
// - Driven data is the word addressed one edge earlier in the read.
// - Data and parity lines drive only while output enable is low.
// - Burst order strap low selects linear, high selects interleaved.
// - Synchronous inputs sampled on the rising edge; read data registered.
// - Two-bit wrapping counter holds burst start and steps through burst.
// - Global write low writes every lane regardless of lane controls.
// - Read on strobe, chip selected, writes idle; select one gates CPU.
// - Read data leaves the output register at the following edge.
// - Leaving deselect, outputs stay off for the first read cycle.
// - Back-to-back reads work; a deselecting edge turns outputs off.
// - First cycle of a processor write ignores write controls and step.
// - Processor write completes at second edge when global write is low.
// - Otherwise byte gate plus lane selects write only chosen lanes.
// - A detected write cycle forces data and parity lines off.
// - Burst step low at an edge advances the counter, reads and writes.
// - Interleaved visits start XOR 0..3; linear adds 0..3 modulo four.
// - Selected only with select one low, two high, three low.
package pbs_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int LANES = 2;
  localparam int BYTE_W = 8;
  localparam int LANE_W = BYTE_W + 1;
  localparam int BURST_W = 2;
  localparam logic ORDER_LINEAR = 1'h0;
  localparam logic [BURST_W-1:0] CNT_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [LANES*LANE_W-1:0] WORD_RST = 18'h00000;

  typedef enum logic [1:0] {
    PBS_DESEL = 2'h0,
    PBS_ACTIVE = 2'h1,
    PBS_SLEEP = 2'h2
  } pbs_state_t;
endpackage : pbs_pkg

// ### rtl/pbs_burst_counter.sv
/*
  Two-bit wrapping burst counter with linear or interleaved order.
  Assumes load and step never arrive together; load wins if they do.
*/
`timescale 1ns/1ps
`default_nettype none
module pbs_burst_counter #(
  parameter int WIDTH = pbs_pkg::BURST_W
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic step,
  input wire logic interleaved,
  output logic [WIDTH-1:0] current,
  output logic [WIDTH-1:0] ahead
);
  import pbs_pkg::*;

  logic [WIDTH-1:0] start;
  logic [WIDTH-1:0] offset;
  logic [WIDTH-1:0] next_offset;

  // Keeping start and offset apart makes both orders one adder or one XOR
  assign next_offset = offset + {{(WIDTH-1){1'b0}}, 1'b1};
  assign current = interleaved ? (start ^ offset) : (start + offset);
  assign ahead = interleaved ? (start ^ next_offset)
                             : (start + next_offset);

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      start <= WIDTH'(CNT_RST);
      offset <= WIDTH'(CNT_RST);
    end
    else if (load)
    begin
      start <= load_value;
      offset <= WIDTH'(CNT_RST);
    end
    else if (step)
    begin
      offset <= next_offset;
    end
  end
endmodule : pbs_burst_counter
`default_nettype wire

// ### rtl/pbs_sram_port.sv
/*
  Synchronous front end and storage of a pipelined burst SRAM, common I/O.
  Assumes all control inputs are synchronous to mclk; the bidirectional
  lines are split into in, out and enable, and the bench resolves the wire.
  Storage is flip-flops; shrink ADDR_BITS for simulation.
*/
`timescale 1ns/1ps
`default_nettype none
module pbs_sram_port #(
  parameter int ADDR_BITS = pbs_pkg::ADDR_W,
  parameter int DATA_BITS = pbs_pkg::DATA_W
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [ADDR_BITS-1:0] addr,
  input wire logic cpu_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic chip_select_one_n,
  input wire logic chip_select_two,
  input wire logic chip_select_three_n,
  input wire logic burst_step_n,
  input wire logic global_write_n,
  input wire logic byte_write_gate_n,
  input wire logic [pbs_pkg::LANES-1:0] byte_lane_select_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order,
  input wire logic [DATA_BITS-1:0] data_in,
  output logic [DATA_BITS-1:0] data_out,
  output logic data_oe,
  input wire logic [pbs_pkg::LANES-1:0] parity_in,
  output logic [pbs_pkg::LANES-1:0] parity_out,
  output logic parity_oe,
  output logic asleep,
  output logic selected
);
  import pbs_pkg::*;

  localparam int DEPTH = 1 << ADDR_BITS;
  localparam int WORD_W = LANES * LANE_W;

  pbs_state_t state;
  pbs_state_t next_state;

  // Strobe qualification
  wire cpu_seen;
  wire ctrl_seen;
  wire strobe;
  wire chip_on;
  wire awake;
  wire begin_access;
  wire deselect;
  wire in_burst;
  wire cont;

  // Write decode
  wire [LANES-1:0] lane_we;
  wire any_lane;
  wire ctrl_write;
  wire cont_write;
  wire do_write;
  wire do_read;
  wire step;
  wire write_pending;

  // Addressing
  wire [BURST_W-1:0] cnt_current;
  wire [BURST_W-1:0] cnt_ahead;
  wire [BURST_W-1:0] low_bits;
  wire [ADDR_BITS-1:0] acc_addr;
  wire interleaved;

  logic [ADDR_BITS-1:0] addr_reg;
  logic order_strap;

  // Data path
  wire [WORD_W-1:0] word_in;
  wire [WORD_W-1:0] word_rd;
  logic [WORD_W-1:0] rd_stage;
  logic rd_pend;
  logic [WORD_W-1:0] out_word;
  logic out_valid;
  logic write_seen;
  wire drive;

  assign cpu_seen = ~cpu_addr_strobe_n & ~chip_select_one_n;
  assign ctrl_seen = ~ctrl_addr_strobe_n & ~cpu_seen;
  assign strobe = cpu_seen | ~ctrl_addr_strobe_n;
  assign chip_on = ~chip_select_one_n & chip_select_two
                   & ~chip_select_three_n;
  assign awake = (state != PBS_SLEEP) & ~sleep_request;
  assign begin_access = awake & strobe & chip_on;
  assign deselect = awake & strobe & ~chip_on;
  assign in_burst = (state == PBS_ACTIVE);
  assign cont = awake & ~strobe & in_burst;

  // Global write overrides the gate and the lane selects
  assign lane_we = {LANES{~global_write_n}}
                   | ({LANES{~byte_write_gate_n}}
                      & ~byte_lane_select_n);
  assign any_lane = |lane_we;

  // A processor-strobe first cycle never writes; the write lands next edge
  assign ctrl_write = begin_access & ctrl_seen & any_lane;
  assign cont_write = cont & any_lane;
  assign do_write = ctrl_write | cont_write;
  assign do_read = (begin_access & ~ctrl_write)
                   | (cont & ~any_lane);
  assign step = cont & ~burst_step_n;

  // Write intent during a burst turns drivers off before its edge
  assign write_pending = in_burst & ~strobe & any_lane;

  assign interleaved = (order_strap != ORDER_LINEAR);
  assign low_bits = step ? cnt_ahead : cnt_current;
  assign acc_addr = begin_access ? addr
                    : {addr_reg[ADDR_BITS-1:BURST_W], low_bits};

  pbs_burst_counter #(
    .WIDTH(BURST_W)
  ) u_counter (
    .mclk(mclk),
    .srst(srst),
    .load(begin_access),
    .load_value(addr[BURST_W-1:0]),
    .step(step),
    .interleaved(interleaved),
    .current(cnt_current),
    .ahead(cnt_ahead)
  );

  // Strap is caught while reset is held; it must not move afterwards
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      order_strap <= burst_order;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      addr_reg <= ADDR_BITS'(ADDR_RST);
    end
    else if (begin_access)
    begin
      addr_reg <= addr;
    end
  end

  // Lane packing: lane i holds parity bit i over data byte i
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      logic [LANE_W-1:0] mem [DEPTH];

      assign word_in[g*LANE_W +: LANE_W] =
        {parity_in[g], data_in[g*BYTE_W +: BYTE_W]};
      assign word_rd[g*LANE_W +: LANE_W] = mem[acc_addr];

      // Unselected lanes keep their contents
      always_ff @(posedge mclk)
      begin
        if (do_write & lane_we[g])
        begin
          mem[acc_addr] <= word_in[g*LANE_W +: LANE_W];
        end
      end

      assign data_out[g*BYTE_W +: BYTE_W] =
        out_word[g*LANE_W +: BYTE_W];
      assign parity_out[g] = out_word[g*LANE_W + BYTE_W];
    end
  endgenerate

  // First stage: core lookup at the access edge
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rd_stage <= WORD_RST;
      rd_pend <= 1'b0;
    end
    else
    begin
      rd_pend <= do_read;
      if (do_read)
      begin
        rd_stage <= word_rd;
      end
    end
  end

  // Output register loads one edge after the read started
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      out_word <= WORD_RST;
    end
    else if (rd_pend)
    begin
      out_word <= rd_stage;
    end
  end

  // Output validity: deselect, sleep and writes clear it at once
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      out_valid <= 1'b0;
    end
    else if (deselect | do_write | ~awake)
    begin
      out_valid <= 1'b0;
    end
    else if (rd_pend)
    begin
      out_valid <= 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      write_seen <= 1'b0;
    end
    else if (do_write)
    begin
      write_seen <= 1'b1;
    end
    else if (do_read | deselect)
    begin
      write_seen <= 1'b0;
    end
  end

  // Output enable acts without the clock, but only on a valid register
  assign drive = out_valid & ~output_enable_n & ~write_seen
                 & ~write_pending & ~sleep_request;
  assign data_oe = drive;
  assign parity_oe = drive;

  always_comb
  begin
    next_state = state;
    case (state)
      PBS_DESEL:
      begin
        if (sleep_request)
        begin
          next_state = PBS_SLEEP;
        end
        else if (begin_access)
        begin
          next_state = PBS_ACTIVE;
        end
      end
      PBS_ACTIVE:
      begin
        if (sleep_request)
        begin
          next_state = PBS_SLEEP;
        end
        else if (deselect)
        begin
          next_state = PBS_DESEL;
        end
      end
      PBS_SLEEP:
      begin
        if (!sleep_request)
        begin
          next_state = PBS_DESEL;
        end
      end
      default:
      begin
        next_state = PBS_DESEL;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state <= PBS_DESEL;
      asleep <= 1'b0;
      selected <= 1'b0;
    end
    else
    begin
      state <= next_state;
      asleep <= (next_state == PBS_SLEEP);
      selected <= (next_state == PBS_ACTIVE);
    end
  end
endmodule : pbs_sram_port
`default_nettype wire

// ### dv/pbs_port_checker.sv
/* Pin checker for pbs_sram_port.
   Assumes one clock mclk and synchronous reset srst. */
`timescale 1ns/1ps
`default_nettype none
module pbs_port_checker (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cpu_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic chip_select_one_n,
  input wire logic chip_select_two,
  input wire logic chip_select_three_n,
  input wire logic global_write_n,
  input wire logic byte_write_gate_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic data_oe,
  input wire logic asleep,
  input wire logic selected
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (srst);
  wire logic quiet = cpu_addr_strobe_n && ctrl_addr_strobe_n;
  wire logic stb = (!cpu_addr_strobe_n && !chip_select_one_n)
    || !ctrl_addr_strobe_n;
  wire logic sel = !chip_select_one_n && chip_select_two
    && !chip_select_three_n;
  wire logic go = stb && !sleep_request && !asleep;
  wire logic nowr = global_write_n && byte_write_gate_n;
  a_oe_gates_data:
    assert property (output_enable_n |-> !data_oe)
      else $error("driving with oe high");
  a_begin_selects:
    assert property (go && sel |=> selected)
      else $error("begin did not select");
  a_deselect_off:
    assert property (go && !sel |=> !selected && !data_oe)
      else $error("deselect left outputs on");
  a_first_hiz:
    assert property ($rose(selected) |-> !data_oe)
      else $error("first cycle driven");
  a_sleep_enter:
    assert property (sleep_request |=> asleep && !data_oe)
      else $error("sleep not entered");
  a_sleep_quiet:
    assert property (sleep_request |-> !data_oe)
      else $error("driving in sleep");
  a_write_hiz:
    assert property (selected && quiet && !global_write_n
      |-> !data_oe ##1 !data_oe) else $error("driving in write");
  a_read_drives:
    assert property (go && sel && nowr && selected ##1
      quiet && nowr && !sleep_request |=> output_enable_n || !nowr
      || sleep_request || data_oe) else $error("read not driven");
  c_first: cover property ($rose(selected));
  c_write: cover property (selected && quiet && !global_write_n);
  c_sleep: cover property (asleep);
endmodule : pbs_port_checker
bind pbs_sram_port pbs_port_checker chk_u (.mclk, .srst,
  .cpu_addr_strobe_n, .ctrl_addr_strobe_n, .chip_select_one_n,
  .chip_select_two, .chip_select_three_n, .global_write_n,
  .byte_write_gate_n, .output_enable_n, .sleep_request, .data_oe,
  .asleep, .selected);
`default_nettype wire

// ### dv/pbs_master_model.sv
/* Bus master side: resolves the shared data and parity wire.
   Assumes the device splits its pins into in, out and enable. */
`timescale 1ns/1ps
`default_nettype none
module pbs_master_model (
  input wire logic mclk,
  input wire logic drv,
  input wire logic oe_n,
  input wire logic [17:0] word,
  input wire logic [17:0] dev,
  input wire logic dev_oe,
  output logic [17:0] bus
);
  logic [17:0] last = 18'h00000;
  // Undriven wire toggles so a stale value never passes for data
  assign bus = dev_oe ? dev : (drv && oe_n) ? word : ~last;
  always @(posedge mclk)
  begin
    last <= bus;
  end
endmodule : pbs_master_model
`default_nettype wire

// ### dv/pbs_sram_port_bench.sv
/* Bench for pbs_sram_port: read and write tasks with expected words.
   Assumes the checker binds itself and the model owns the bus. */
`timescale 1ns/1ps
`default_nettype none
module pbs_sram_port_bench;
  logic mclk = 0, srst = 1, cpu = 1, ctl = 1, cs1 = 1, cs2 = 1, cs3 = 0;
  logic stp = 1, gw = 1, byte_write_gate = 1, oe = 1, slp = 0, ord = 0, drv = 0;
  logic doe, poe, asl, sel;
  logic [1:0] bls = 2'h3, po;
  logic [3:0] adr = 4'h0;
  logic [15:0] dq;
  logic [17:0] mw = 18'h00000, bus;
  logic [17:0] mem [16];
  int num_errors = 0, cmp_count = 0;
  always #2 mclk = ~mclk;
  pbs_sram_port #(.ADDR_BITS(4)) dut_u (.mclk(mclk), .srst(srst),
    .addr(adr), .cpu_addr_strobe_n(cpu), .ctrl_addr_strobe_n(ctl),
    .chip_select_one_n(cs1), .chip_select_two(cs2),
    .chip_select_three_n(cs3), .burst_step_n(stp), .global_write_n(gw),
    .byte_write_gate_n(byte_write_gate), .byte_lane_select_n(bls),
    .output_enable_n(oe), .sleep_request(slp), .burst_order(ord),
    .data_in(bus[15:0]), .data_out(dq), .data_oe(doe),
    .parity_in(bus[17:16]), .parity_out(po), .parity_oe(poe),
    .asleep(asl), .selected(sel));
  pbs_master_model mst_u (.mclk(mclk), .drv(drv), .oe_n(oe), .word(mw),
    .dev({po, dq}), .dev_oe(doe), .bus(bus));
  task automatic chk(input string w, input logic [17:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected %s exp %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic tk;
    @(negedge mclk);
    {cpu, ctl, stp, gw, byte_write_gate, bls, drv} = 8'hFE;
    cs1 = 0;
  endtask : tk
  task automatic rst(input logic o);
    tk;
    srst = 1;
    ord = o;
    repeat (4) tk;
    srst = 0;
  endtask : rst
  task automatic dsl;
    tk;
    cs1 = 1;
    ctl = 0;
    tk;
    cs1 = 1;
    cpu = 0;
    tk;
    chk("deselect", 18'({doe, sel}), 18'h00000);
    chk("cpu_ignored", 18'({doe, sel}), 18'h00000);
  endtask : dsl
  task automatic wb(input logic [3:0] a, input int n, input logic g, b,
    input logic [1:0] l, input logic both);
    logic [17:0] m;
    logic [1:0] e;
    m = g ? (b ? 18'h00000 : {~l, {8{~l[1]}}, {8{~l[0]}}}) : 18'h3FFFF;
    tk;
    {cpu, ctl, gw, stp} = {1'h0, !both, 2'h0};
    adr = a;
    for (int k = 0; k < n; k++)
    begin
      tk;
      {gw, byte_write_gate, bls, stp, oe, drv} = {g, b, l, k == 0, 2'h3};
      mw = {a, 14'h1A3C} ^ 18'(k * 257);
      e = ord ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k);
      mem[{a[3:2], e}] = (mem[{a[3:2], e}] & ~m) | (mw & m);
    end
  endtask : wb
  task automatic rd(input logic [3:0] a, input logic fr);
    tk;
    {cpu, ctl} = fr ? 2'h1 : 2'h2;
    adr = a;
    oe = 0;
    tk;
    if (fr) chk("first_oe", 18'(doe), 18'h00000);
    tk;
    chk("rd_word", {po, dq}, mem[a]);
    chk("rd_oe", 18'({poe, doe}), 18'h00003);
    oe = 1;
    #1 chk("oe_off", 18'({poe, doe}), 18'h00000);
  endtask : rd
  initial
  begin
    rst(0);
    dsl;
    wb(4'h6, 4, 0, 1, 2'h3, 0);
    dsl;
    for (int k = 4; k < 8; k++)
      rd(4'(k), k == 4);
    wb(4'h4, 1, 1, 0, 2'h2, 1);
    rd(4'h4, 0);
    $display("linear burst and lane write done");
    rst(1);
    dsl;
    wb(4'h9, 4, 0, 1, 2'h3, 0);
    dsl;
    for (int k = 8; k < 12; k++)
      rd(4'(k), k == 8);
    $display("interleaved burst done");
    dsl;
    slp = 1;
    repeat (2) tk;
    chk("sleep", 18'({asl, doe}), 18'h00002);
    slp = 0;
    repeat (3) tk;
    rd(4'hA, 1);
    $display("sleep done");
    give_verdict;
  end
  // Whole run is near 72 cycles; this leaves ample margin
  initial
  begin
    #4000;
    num_errors++;
    give_verdict;
  end
endmodule : pbs_sram_port_bench
`default_nettype wire
